/* File: core/wdt_pkg.sv */
// Package: register offsets, field layout, reset values and service codes
`default_nettype none
package wdt_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_PROT_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SERVICE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 4'hc;
  // Protection control field positions
  localparam int unsigned TC_LSB = 16;
  localparam int unsigned BIT_ENABLE = 2;
  localparam int unsigned BIT_SELECT = 1;
  localparam int unsigned BIT_FREEZE_STOP = 3;
  localparam int unsigned BIT_PRESCALE = 0;
  localparam int unsigned BIT_LOCKED = 4;
  // Status and mask bit positions
  localparam int unsigned ST_EXPIRED = 0;
  localparam int unsigned ST_BAD_CODE = 1;
  localparam int unsigned ST_W = 2;
  // Reset values
  localparam logic [15:0] TC_RESET = 16'hffff;
  localparam logic RST_ENABLE = 1'b1;
  // Untouched watchdog must reset the system, not raise NMI
  localparam logic RST_SELECT = 1'b0;
  localparam logic RST_FREEZE_STOP = 1'b1;
  localparam logic RST_PRESCALE = 1'b1;
  // Service codes
  localparam logic [15:0] CODE_ARM = 16'h556c;
  localparam logic [15:0] CODE_FIRE = 16'haa39;
  // Prescaler
  localparam int unsigned PRESCALE_DIV = 2048;
  localparam int unsigned PRESCALE_W = 11;

  typedef enum logic {SVC_IDLE, SVC_ARMED} svc_state_e;

  typedef struct packed {
    logic [15:0] timeout;
    logic enable;
    logic select_nmi;
    logic freeze_stop;
    logic prescale;
  } prot_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage : wdt_pkg
`default_nettype wire

/* File: core/wdt_prescaler.sv */
// Divide-by-2048 tick generator for the watchdog counter
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int unsigned DIV = PRESCALE_DIV
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  // Tick
  output logic tick_o
);
  logic [PRESCALE_W-1:0] div_cnt;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= '0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      div_cnt <= '0;
      tick_o <= 1'b0;
    end else if (run_i) begin
      tick_o <= (div_cnt == PRESCALE_W'(DIV - 1));
      div_cnt <= (div_cnt == PRESCALE_W'(DIV - 1)) ? '0 : div_cnt + 1'b1;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule // wdt_prescaler
`default_nettype wire

/* File: core/software_watchdog_timer.sv */
// Software watchdog timer with two-word service sequence
`default_nettype none
module software_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int unsigned COUNT_W = 16,
  parameter int unsigned DIV = PRESCALE_DIV
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // System state
  input wire logic freeze_i,
  input wire logic low_power_i,
  // Expiry requests and interrupt
  output logic sys_reset_req_o,
  output logic nmi_req_o,
  output logic irq_o
);
  prot_ctrl_s ctrl;
  logic ctrl_locked;
  logic [15:0] svc_code;
  svc_state_e svc_state;
  logic [COUNT_W-1:0] count;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic expired;
  bus_req_s req;
  logic wr_ctrl;
  logic wr_svc;
  logic service_done;
  logic bad_code;
  logic halted;
  logic run;
  logic tick;
  logic step;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wr_ctrl = req.wr && (req.addr == OFS_PROT_CTRL);
  assign wr_svc = req.wr && (req.addr == OFS_SERVICE);
  assign svc_code = req.wdata[15:0];
  assign service_done = wr_svc && (svc_state == SVC_ARMED) && (svc_code == CODE_FIRE);
  assign bad_code = wr_svc && (svc_code != CODE_ARM) && (svc_code != CODE_FIRE);
  // Low power, and freeze while freeze_stop is set, both stop the counter from stepping
  assign halted = low_power_i || (freeze_i && ctrl.freeze_stop);
  assign run = ctrl.enable && !halted && !expired;
  assign step = run && (ctrl.prescale ? tick : 1'b1);

  wdt_prescaler #(
    .DIV(DIV)
  ) u_prescaler (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run && ctrl.prescale),
    .clear_i(service_done),
    .tick_o(tick)
  );

  // Protection control: timeout always writable, enable once only
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl.timeout <= TC_RESET;
      ctrl.enable <= RST_ENABLE;
      ctrl.select_nmi <= RST_SELECT;
      ctrl.freeze_stop <= RST_FREEZE_STOP;
      ctrl.prescale <= RST_PRESCALE;
      ctrl_locked <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl.timeout <= req.wdata[TC_LSB +: 16];
      ctrl.select_nmi <= req.wdata[BIT_SELECT];
      ctrl.freeze_stop <= req.wdata[BIT_FREEZE_STOP];
      ctrl.prescale <= req.wdata[BIT_PRESCALE];
      ctrl_locked <= 1'b1;
      if (!ctrl_locked) begin
        ctrl.enable <= req.wdata[BIT_ENABLE];
      end
    end
  end

  // Service sequence; reads and other addresses never touch it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      svc_state <= SVC_IDLE;
    end else if (wr_svc) begin
      case (svc_state)
        SVC_IDLE: begin
          if (svc_code == CODE_ARM) begin
            svc_state <= SVC_ARMED;
          end
        end
        SVC_ARMED: begin
          if (svc_code == CODE_FIRE) begin
            svc_state <= SVC_IDLE;
          end else if (svc_code != CODE_ARM) begin
            svc_state <= SVC_IDLE;
          end
        end
        default: svc_state <= SVC_IDLE;
      endcase
    end
  end

  // Down-counter; a fresh load only on reset or completed service
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= COUNT_W'(TC_RESET);
      expired <= 1'b0;
    end else if (service_done && !expired) begin
      count <= COUNT_W'(ctrl.timeout);
    end else if (step) begin
      if (count == '0) begin
        expired <= 1'b1;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  // Expiry request held until system reset clears the block, on the output that select_nmi picks each cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_reset_req_o <= 1'b0;
      nmi_req_o <= 1'b0;
    end else begin
      sys_reset_req_o <= expired && !ctrl.select_nmi;
      nmi_req_o <= expired && ctrl.select_nmi;
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status <= '0;
      mask <= '0;
    end else begin
      if (req.wr && (req.addr == OFS_INT_STATUS)) begin
        mask <= req.wdata[16 +: ST_W];
      end
      status <= (status & ~((req.wr && (req.addr == OFS_INT_STATUS)) ? req.wdata[ST_W-1:0] : '0))
        | {bad_code, step && (count == '0) && !service_done};
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // Read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (!req.rd) begin
      rdata_o <= '0;
    end else if (req.addr == OFS_PROT_CTRL) begin
      rdata_o <= {ctrl.timeout, 11'h000, ctrl_locked, ctrl.freeze_stop, ctrl.enable, ctrl.select_nmi,
        ctrl.prescale};
    end else if (req.addr == OFS_SERVICE) begin
      rdata_o <= {31'h0000_0000, svc_state == SVC_ARMED};
    end else if (req.addr == OFS_COUNT) begin
      rdata_o <= {{(DATA_W-COUNT_W){1'b0}}, count};
    end else if (req.addr == OFS_INT_STATUS) begin
      rdata_o <= {14'h0000, mask, 14'h0000, status};
    end else begin
      rdata_o <= '0;
    end
  end

  // Checks
  property p_enable_lock;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_ctrl && ctrl_locked) |=> $stable(ctrl.enable);
  endproperty
  a_enable_lock: assert property (p_enable_lock) else $error("enable changed after lock");

  property p_service_reload;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (service_done && !expired) |=> (count == COUNT_W'($past(ctrl.timeout)));
  endproperty
  a_service_reload: assert property (p_service_reload) else $error("no reload on service");

  property p_bad_abandon;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      bad_code |=> (svc_state == SVC_IDLE);
  endproperty
  a_bad_abandon: assert property (p_bad_abandon) else $error("bad code kept sequence");

  property p_hold_armed;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (svc_state == SVC_ARMED && !wr_svc) |=> (svc_state == SVC_ARMED);
  endproperty
  a_hold_armed: assert property (p_hold_armed) else $error("service state lost");

  property p_disabled_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!ctrl.enable && !service_done) |=> $stable(count);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("count moved while disabled");

  property p_low_power_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (low_power_i && !service_done) |=> (count == $past(count));
  endproperty
  a_low_power_hold: assert property (p_low_power_hold) else $error("count moved in low power");

  property p_expiry_out;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (step && count == '0 && !service_done) |=> ##1 (sys_reset_req_o || nmi_req_o);
  endproperty
  a_expiry_out: assert property (p_expiry_out) else $error("no expiry request at zero");

  property p_select;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      nmi_req_o |-> $past(ctrl.select_nmi) && !sys_reset_req_o;
  endproperty
  a_select: assert property (p_select) else $error("wrong expiry response");

  property p_no_prescale_step;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (run && !ctrl.prescale && count != '0 && !service_done) |=> (count == $past(count) - 1'b1);
  endproperty
  a_no_prescale_step: assert property (p_no_prescale_step) else $error("counter did not step");

  property p_lock_sets;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_ctrl |=> ctrl_locked;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock not set by control write");

  property p_lock_sticky;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      ctrl_locked |=> ctrl_locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released without reset");

  property p_enable_first_write;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_ctrl && !ctrl_locked) |=> (ctrl.enable == $past(wdata_i[BIT_ENABLE]));
  endproperty
  a_enable_first_write: assert property (p_enable_first_write) else $error("first write missed enable");

  property p_select_write;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_ctrl |=> (ctrl.select_nmi == $past(wdata_i[BIT_SELECT]));
  endproperty
  a_select_write: assert property (p_select_write) else $error("select bit not written");

  property p_arm;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_svc && svc_state == SVC_IDLE && svc_code == CODE_ARM) |=> (svc_state == SVC_ARMED);
  endproperty
  a_arm: assert property (p_arm) else $error("first code did not arm");

  property p_fire_idle;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      service_done |=> (svc_state == SVC_IDLE);
  endproperty
  a_fire_idle: assert property (p_fire_idle) else $error("sequence not restarted after service");

  property p_arm_repeat;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_svc && svc_state == SVC_ARMED && svc_code == CODE_ARM) |=> (svc_state == SVC_ARMED);
  endproperty
  a_arm_repeat: assert property (p_arm_repeat) else $error("repeated first code lost arming");

  property p_idle_other;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_svc && svc_state == SVC_IDLE && svc_code != CODE_ARM) |=> (svc_state == SVC_IDLE);
  endproperty
  a_idle_other: assert property (p_idle_other) else $error("armed without first code");

  property p_read_no_effect;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (rd_i && !wr_i) |=> $stable(svc_state);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read moved service state");

  property p_count_source;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!service_done && !step) |=> $stable(count);
  endproperty
  a_count_source: assert property (p_count_source) else $error("count moved without step or service");

  property p_step_decrement;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (step && count != '0 && !service_done) |=> (count == $past(count) - 1'b1);
  endproperty
  a_step_decrement: assert property (p_step_decrement) else $error("step did not decrement");

  property p_prescale_gap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (ctrl.prescale && !tick && !service_done) |=> $stable(count);
  endproperty
  a_prescale_gap: assert property (p_prescale_gap) else $error("count moved between ticks");

  property p_tick_single;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("prescaler tick too long");

  property p_freeze_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (freeze_i && ctrl.freeze_stop && !service_done) |=> $stable(count);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("count moved in freeze");

  property p_expire_at_zero;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (step && count == '0 && !service_done) |=> expired;
  endproperty
  a_expire_at_zero: assert property (p_expire_at_zero) else $error("no expiry at zero");

  property p_expired_sticky;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      expired |=> expired;
  endproperty
  a_expired_sticky: assert property (p_expired_sticky) else $error("expiry dropped without reset");

  property p_disabled_no_expiry;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!ctrl.enable && !expired) |=> !expired;
  endproperty
  a_disabled_no_expiry: assert property (p_disabled_no_expiry) else $error("expired while disabled");

  property p_bad_code_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      bad_code |=> status[ST_BAD_CODE];
  endproperty
  a_bad_code_flag: assert property (p_bad_code_flag) else $error("bad code not flagged");
endmodule // software_watchdog_timer
`default_nettype wire

/* File: tb/software_watchdog_timer_tb_top.sv */
// Self-checking testbench for the software watchdog timer
`default_nettype none
`define CHK(g, e) check_eq(32'(g), 32'(e))
module software_watchdog_timer_tb_top
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short prescaler so the divided mode fits the run
  localparam int unsigned DIV_TB = 4;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic freeze_i = 1'b0;
  logic low_power_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic sys_reset_req_o, nmi_req_o, irq_o;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] a, b;
  int n;

  software_watchdog_timer #(.COUNT_W(16), .DIV(DIV_TB)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .freeze_i(freeze_i), .low_power_i(low_power_i),
    .sys_reset_req_o(sys_reset_req_o), .nmi_req_o(nmi_req_o), .irq_o(irq_o));

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] ad, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(posedge sys_clk_i);
    d = rdata_o;
  endtask

  task automatic service();
    wr(OFS_SERVICE, 32'(CODE_ARM));
    wr(OFS_SERVICE, 32'(CODE_FIRE));
  endtask

  // Cycles until a request output rises, bounded
  task automatic wait_req(input logic use_nmi, input int lim, output int cyc);
    cyc = 0;
    while ((use_nmi ? nmi_req_o : sys_reset_req_o) !== 1'b1 && cyc < lim) begin
      @(posedge sys_clk_i);
      cyc++;
    end
  endtask

  task automatic t_reset_values();
    rd(OFS_COUNT, a);
    `CHK(a, 32'h0000_ffff);
    rd(OFS_PROT_CTRL, a);
    `CHK(a, 32'hffff000d);
    rd(OFS_SERVICE, a);
    `CHK(a, 32'h0);
    rd(4'h2, a);
    `CHK(a, 32'h0);
    `CHK({sys_reset_req_o, nmi_req_o, irq_o}, 3'h0);
  endtask

  task automatic t_program_service();
    wr(OFS_PROT_CTRL, 32'h0100_000c);
    rd(OFS_PROT_CTRL, a);
    `CHK(a, 32'h0100_001c);
    wr(OFS_SERVICE, 32'(CODE_ARM));
    rd(OFS_SERVICE, a);
    `CHK(a[0], 1'b1);
    wr(OFS_INT_STATUS, 32'h0002_0000);
    wr(OFS_SERVICE, 32'(CODE_FIRE));
    rd(OFS_SERVICE, a);
    `CHK(a[0], 1'b0);
    rd(OFS_COUNT, a);
    `CHK(a <= 32'h100 && a >= 32'hf8, 1'b1);
  endtask

  task automatic t_hold();
    low_power_i <= 1'b1;
    rd(OFS_COUNT, a);
    repeat (10) @(posedge sys_clk_i);
    rd(OFS_COUNT, b);
    `CHK(b, a);
    low_power_i <= 1'b0;
    freeze_i <= 1'b1;
    rd(OFS_COUNT, a);
    repeat (10) @(posedge sys_clk_i);
    rd(OFS_COUNT, b);
    `CHK(b, a);
    freeze_i <= 1'b0;
    rd(OFS_COUNT, a);
    `CHK(a < b, 1'b1);
  endtask

  task automatic t_bad_code();
    wr(OFS_SERVICE, 32'(CODE_ARM));
    wr(OFS_SERVICE, 32'h0000_1234);
    rd(OFS_SERVICE, a);
    `CHK(a[0], 1'b0);
    rd(OFS_COUNT, b);
    wr(OFS_SERVICE, 32'(CODE_FIRE));
    rd(OFS_COUNT, a);
    `CHK(a < b, 1'b1);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b1);
    rd(OFS_INT_STATUS, a);
    `CHK(a, 32'h0002_0002);
    wr(OFS_INT_STATUS, 32'h0002_0002);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b0);
  endtask

  task automatic t_new_timeout_expiry();
    // Enable written as zero: must stay set once locked
    wr(OFS_PROT_CTRL, 32'h0040_0008);
    rd(OFS_PROT_CTRL, a);
    `CHK(a, 32'h0040_001c);
    rd(OFS_COUNT, a);
    `CHK(a > 32'h40, 1'b1);
    service();
    rd(OFS_COUNT, a);
    `CHK(a <= 32'h40, 1'b1);
    wait_req(1'b0, 200, n);
    `CHK(n >= 32'h3c && n <= 32'h44, 1'b1);
    `CHK(nmi_req_o, 1'b0);
    rd(OFS_INT_STATUS, a);
    `CHK(a, 32'h0002_0001);
  endtask

  task automatic t_disabled();
    do_reset();
    wr(OFS_PROT_CTRL, 32'h0008_0002);
    service();
    rd(OFS_COUNT, a);
    repeat (60) @(posedge sys_clk_i);
    rd(OFS_COUNT, b);
    `CHK(b, a);
    `CHK({sys_reset_req_o, nmi_req_o}, 2'h0);
  endtask

  task automatic t_nmi_prescaled();
    do_reset();
    // Freeze must not stop the count while stop-on-freeze is clear
    freeze_i <= 1'b1;
    wr(OFS_PROT_CTRL, 32'h0004_0007);
    service();
    // Five steps of four clocks each, plus transfer slack
    wait_req(1'b1, 200, n);
    `CHK(n >= 14 && n <= 24, 1'b1);
    `CHK(sys_reset_req_o, 1'b0);
    freeze_i <= 1'b0;
  endtask

  initial begin
    // Whole run is a few hundred cycles
    #(40 * 20000);
    failures++;
    give_verdict();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_program_service();
    t_hold();
    t_bad_code();
    t_new_timeout_expiry();
    t_disabled();
    t_nmi_prescaled();
    give_verdict();
  end
endmodule // software_watchdog_timer_tb_top
`default_nettype wire
